//--- bench/adc_output_demux_sync_tb_top.sv
// Self-checking bench for the sample output demux block
`timescale 1ns/10ps
`default_nettype none
module adc_output_demux_sync_tb_top
    import dmx_pkg::*;
;
    logic                ref_clk          = 1'b0;
    logic                srst             = 1'b1;
    logic                sample_clock_pos = 1'b1;
    logic                sync_reset_pos   = 1'b0;
    logic [DATA_W-1:0]   core_sample      = '0;
    logic [TEMP_W-1:0]   die_temp         = 8'h3c;
    logic [ADDR_W-1:0]   reg_addr         = '0;
    logic [REG_W-1:0]    reg_wdata        = '0;
    logic                reg_wr           = 1'b0;
    logic                reg_rd           = 1'b0;
    logic [REG_W-1:0]    reg_rdata;
    logic [DATA_W-1:0]   bus_a_data, bus_b_data;
    logic                sync_marker_bus_a, sync_marker_bus_b, divided_output_clock;
    logic [OFFS_W-1:0]   offset_trim;
    logic [GAIN_W-1:0]   gain_trim;
    logic [FINE_W-1:0]   fine_phase_trim;
    logic [COARSE_W-1:0] coarse_phase_trim;
    logic [1:0]          ph   = 2'h0;
    logic [11:0]         nf   = 12'h0;
    logic                twos = 1'b0;
    int                  t_fall[4096];
    int                  lat_single = 0;
    int                  n_sync     = 0;
    int                  n_errors   = 0;
    int                  num_checks = 0;
    logic [15:0]         rst_val[5] = '{16'h0000, 16'h0100, 16'h0800, 16'h0000, 16'h0000};
    logic [15:0]         mask[5]    = '{16'h000f, 16'h01ff, 16'h0fff, 16'h003f, 16'h001f};
    logic [3:0]          modes[6]   = '{4'h0, 4'hc, 4'h1, 4'h3, 4'h5, 4'hf};
    int                  da[6]      = '{0, 0, 2, 2, 2, 2};
    int                  db[6]      = '{-1, -1, 6, 2, 6, 2};

    dmx_output_demux i_dmx_output_demux (
        .ref_clk(ref_clk), .srst(srst), .sample_clock_pos(sample_clock_pos),
        .sync_reset_pos(sync_reset_pos), .core_sample(core_sample), .die_temp(die_temp),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .bus_a_data(bus_a_data), .bus_b_data(bus_b_data),
        .sync_marker_bus_a(sync_marker_bus_a), .sync_marker_bus_b(sync_marker_bus_b),
        .divided_output_clock(divided_output_clock), .offset_trim(offset_trim),
        .gain_trim(gain_trim), .fine_phase_trim(fine_phase_trim),
        .coarse_phase_trim(coarse_phase_trim));
    dmx_capture_model i_dmx_capture_model (
        .ref_clk(ref_clk), .bus_a_data(bus_a_data), .bus_b_data(bus_b_data),
        .sync_marker_bus_a(sync_marker_bus_a), .sync_marker_bus_b(sync_marker_bus_b),
        .divided_output_clock(divided_output_clock));

    initial
    begin
        forever #5 ref_clk = ~ref_clk;
    end
    // Sample clock at a quarter of ref_clk; rotated count so the top bit toggles
    always @(posedge ref_clk)
    begin
        ph <= ph + 2'h1;
        if (ph == 2'h1)
        begin
            sample_clock_pos <= 1'b0;
            core_sample <= {nf[0], nf[11:1]};
            t_fall[nf] <= i_dmx_capture_model.cyc;
            nf <= nf + 12'h1;
        end
        if (ph == 2'h3)
            sample_clock_pos <= 1'b1;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        num_checks++;
        if (seen !== want)
        begin
            n_errors++;
            $display("BAD %0t: saw %h, wanted %h", $time, seen, want);
        end
    endtask
    task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic reg_read(input logic [3:0] a, output logic [15:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    function automatic logic [11:0] idx_of(input logic [11:0] w);
        logic [11:0] n;
        n = twos ? w : w ^ 12'h800;
        return {n[10:0], n[11]};
    endfunction
    task automatic set_ctrl(input logic [3:0] ctrl);
        reg_write(ADDR_CTRL, {12'h000, ctrl});
        twos = ctrl[CTRL_TWOS];
        // Words already in flight keep the old number format; let them drain
        repeat (60) @(posedge ref_clk);
        #1 i_dmx_capture_model.clear();
    endtask

    task automatic test_regs();
        logic [15:0] d;
        for (int i = 0; i < 5; i++)
        begin
            reg_read(4'(i), d);
            check(d, rst_val[i]);
        end
        for (int i = 1; i < 5; i++)
        begin
            reg_write(4'(i), 16'hffff);
            reg_read(4'(i), d);
            check(d, mask[i]);
        end
        check({offset_trim, gain_trim, fine_phase_trim, coarse_phase_trim}, '1);
        @(posedge ref_clk);
        die_temp <= 8'ha7;
        reg_write(ADDR_TEMP, 16'h0055);
        reg_write(4'h8, 16'hffff);
        reg_read(ADDR_TEMP, d);
        check(d, 16'h00a7);
        reg_read(4'h8, d);
        check(d, 16'h0000);
        reg_read(ADDR_CTRL, d);
        check(d, 16'h0000);
    endtask

    task automatic check_bus(input bit b, input int dl);
        logic [12:0] w;
        logic [11:0] n;
        logic [11:0] prev;
        int          c;
        int          sz;
        sz = b ? i_dmx_capture_model.log_b.size() : i_dmx_capture_model.log_a.size();
        check(sz >= 19, 1'b1);
        for (int k = 0; k < sz; k++)
        begin
            w = b ? i_dmx_capture_model.log_b[k] : i_dmx_capture_model.log_a[k];
            c = b ? i_dmx_capture_model.cyc_b[k] : i_dmx_capture_model.cyc_a[k];
            n = idx_of(w[11:0]);
            if (lat_single == 0)
                lat_single = c - t_fall[n];
            check(c - t_fall[n], lat_single + dl);
            if (k > 0)
                check(12'(n - prev), (dl > 0) ? 2 : 1);
            prev = n;
        end
    endtask
    task automatic run_mode(input logic [3:0] ctrl, input int dla, input int dlb);
        set_ctrl(ctrl);
        repeat (160) @(posedge ref_clk);
        #1;
        check(i_dmx_capture_model.toggles, ctrl[CTRL_DIV4] ? 20 : 40);
        check_bus(1'b0, dla);
        if (dlb < 0)
        begin
            check(i_dmx_capture_model.log_b.size(), 0);
            check(bus_b_data, 0);
        end
        else
            check_bus(1'b1, dlb);
    endtask

    task automatic test_sync(input logic [3:0] ctrl, input int hold, input int gap,
                             input int pulses);
        logic [11:0] want[$];
        logic [12:0] w;
        logic [15:0] d;
        logic        lv0;
        int          k;
        int          sz;
        set_ctrl(ctrl);
        for (int p = 0; p < pulses; p++)
        begin
            @(posedge ref_clk);
            while (ph != 2'h3)
                @(posedge ref_clk);
            // Raised half a sample period ahead of the fall, dropped after it
            sync_reset_pos <= 1'b1;
            want.push_back(nf);
            repeat (hold) @(posedge ref_clk);
            sync_reset_pos <= 1'b0;
            if (gap > 0)
            begin
                repeat (4) @(posedge ref_clk);
                #1;
                if (p == 0)
                    lv0 = divided_output_clock;
                // Two edge events after the reset phase: still low
                check(divided_output_clock, 1'b0);
                check(divided_output_clock, lv0);
            end
            repeat (gap) @(posedge ref_clk);
        end
        repeat (60) @(posedge ref_clk);
        #1 k = 0;
        sz = ctrl[CTRL_DUAL] ? i_dmx_capture_model.log_b.size()
                             : i_dmx_capture_model.log_a.size();
        for (int i = 0; i < sz; i++)
        begin
            w = ctrl[CTRL_DUAL] ? i_dmx_capture_model.log_b[i] : i_dmx_capture_model.log_a[i];
            if (w[12])
            begin
                check(idx_of(w[11:0]), want[k]);
                k++;
            end
        end
        check(k, pulses);
        n_sync += pulses;
        reg_read(ADDR_STATUS, d);
        check(d & 16'hf8ff, 16'(n_sync));
    endtask

    task automatic tally_and_finish();
        if (n_errors == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Whole run is under two thousand cycles; this bound only catches a hang
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        n_errors++;
        tally_and_finish();
    end
    initial
    begin
        repeat (3) @(posedge ref_clk);
        srst <= 1'b0;
        test_regs();
        for (int m = 0; m < 6; m++)
            run_mode(modes[m], da[m], db[m]);
        // Three extra cycles: edge detect, event register, capture log
        check(lat_single, 2 * LAT_SINGLE_HALF + 3);
        test_sync(4'h1, 4, 0, 3);
        test_sync(4'h3, 40, 0, 1);
        test_sync(4'hc, 4, 12, 3);
        tally_and_finish();
    end
endmodule // adc_output_demux_sync_tb_top
`default_nettype wire

//--- bench/dmx_capture_model.sv
// Capture model: logs every word that lands on the two sample buses
`timescale 1ns/10ps
`default_nettype none
module dmx_capture_model
    import dmx_pkg::*;
(
    input wire logic              ref_clk,
    input wire logic [DATA_W-1:0] bus_a_data,
    input wire logic [DATA_W-1:0] bus_b_data,
    input wire logic              sync_marker_bus_a,
    input wire logic              sync_marker_bus_b,
    input wire logic              divided_output_clock
);
    logic [DATA_W-1:0] prev_a  = '0;
    logic [DATA_W-1:0] prev_b  = '0;
    logic              prev_ck = 1'b0;
    logic [DATA_W:0]   log_a[$];
    logic [DATA_W:0]   log_b[$];
    int                cyc_a[$];
    int                cyc_b[$];
    int                cyc     = 0;
    int                toggles = 0;
    // No strobe travels with the words, so a new word is seen as a change
    // Limitation: two equal words in a row would merge into one entry
    always @(posedge ref_clk)
    begin
        cyc <= cyc + 1;
        prev_a <= bus_a_data;
        prev_b <= bus_b_data;
        prev_ck <= divided_output_clock;
        if (bus_a_data !== prev_a)
        begin
            log_a.push_back({sync_marker_bus_a, bus_a_data});
            cyc_a.push_back(cyc);
        end
        if (bus_b_data !== prev_b)
        begin
            log_b.push_back({sync_marker_bus_b, bus_b_data});
            cyc_b.push_back(cyc);
        end
        if (divided_output_clock !== prev_ck)
            toggles <= toggles + 1;
    end
    task automatic clear();
        log_a.delete();
        log_b.delete();
        cyc_a.delete();
        cyc_b.delete();
        toggles = 0;
    endtask
endmodule // dmx_capture_model
`default_nettype wire

//--- rtl/dmx_edge_track.sv
// Sample clock edge detector and reset capture
`timescale 1ns/10ps
`default_nettype none
module dmx_edge_track
    import dmx_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic srst,
    input  wire logic sample_clock_pos,
    input  wire logic sync_reset_pos,
    output logic      fall_evt,
    output logic      rise_evt,
    output logic      sync_evt
);
    typedef struct packed {
        logic prev_clk;
        logic rst_cap;
        logic fall;
        logic rise;
        logic sync;
    } dmx_edge_s;

    dmx_edge_s st;
    dmx_edge_s next_st;

    always_comb
    begin
        next_st      = st;
        next_st.prev_clk = sample_clock_pos;
        next_st.fall = st.prev_clk & ~sample_clock_pos;
        next_st.rise = ~st.prev_clk & sample_clock_pos;
        next_st.sync = 1'b0;
        if (st.prev_clk && !sample_clock_pos)
        begin
            next_st.rst_cap = sync_reset_pos;
            next_st.sync = sync_reset_pos & ~st.rst_cap;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
            st <= '0;
        else
            st <= next_st;
    end

    assign fall_evt = st.fall;
    assign rise_evt = st.rise;
    assign sync_evt = st.sync;

    a_sync_on_step: assert property (@(posedge ref_clk) disable iff (srst)
        (st.prev_clk && !sample_clock_pos && sync_reset_pos && !st.rst_cap) |=> sync_evt)
        else $error("Captured reset step gave no sync event");

    a_sync_needs_fall: assert property (@(posedge ref_clk) disable iff (srst)
        sync_evt |-> fall_evt && $past(st.prev_clk) && !$past(sample_clock_pos))
        else $error("Sync event without a sample clock falling edge");
endmodule // dmx_edge_track
`default_nettype wire

//--- rtl/dmx_output_demux.sv
// Output formatting, demux, sync marker, clock divider and trim registers
`timescale 1ns/10ps
`default_nettype none
module dmx_output_demux
    import dmx_pkg::*;
(
    input  wire logic                 ref_clk,
    input  wire logic                 srst,
    input  wire logic                 sample_clock_pos,
    input  wire logic                 sync_reset_pos,
    input  wire logic [DATA_W-1:0]    core_sample,
    input  wire logic [TEMP_W-1:0]    die_temp,
    input  wire logic [ADDR_W-1:0]    reg_addr,
    input  wire logic [REG_W-1:0]     reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output logic      [REG_W-1:0]     reg_rdata,
    output logic      [DATA_W-1:0]    bus_a_data,
    output logic      [DATA_W-1:0]    bus_b_data,
    output logic                      sync_marker_bus_a,
    output logic                      sync_marker_bus_b,
    output logic                      divided_output_clock,
    output logic      [OFFS_W-1:0]    offset_trim,
    output logic      [GAIN_W-1:0]    gain_trim,
    output logic      [FINE_W-1:0]    fine_phase_trim,
    output logic      [COARSE_W-1:0]  coarse_phase_trim
);
    typedef struct packed {
        logic              valid;
        logic              sel;
        logic              sync;
        logic [DATA_W-1:0] data;
    } dmx_slot_s;

    typedef struct packed {
        dmx_slot_s [PIPE_DEPTH-1:0] pipe;
        logic                       samp_sel;
        logic [1:0]                 div_cnt;
        logic                       clk_out;
        logic [DATA_W-1:0]          bus_a;
        logic [DATA_W-1:0]          bus_b;
        logic                       mark_a;
        logic                       mark_b;
        logic [3:0]                 ctrl;
        logic [OFFS_W-1:0]          offs;
        logic [GAIN_W-1:0]          gain;
        logic [FINE_W-1:0]          fine;
        logic [COARSE_W-1:0]        coarse;
        logic [TEMP_W-1:0]          temp;
        logic [7:0]                 sync_cnt;
        logic [REG_W-1:0]           rdata;
    } dmx_state_s;

    dmx_state_s st;
    dmx_state_s next_st;
    logic       fall_evt;
    logic       rise_evt;
    logic       sync_evt;
    logic       adv;
    logic       dual;
    logic       stagger;
    logic       div4;
    logic       twos;
    dmx_slot_s  entry;

    // Offset binary from the core's two's complement word
    function automatic logic [DATA_W-1:0] fmt_word(
        input logic [DATA_W-1:0] d,
        input logic              use_twos
    );
        fmt_word = use_twos ? d : {~d[DATA_W-1], d[DATA_W-2:0]};
    endfunction

    // Zero-extend a narrow field onto the read bus
    function automatic logic [REG_W-1:0] widen(
        input logic [REG_W-1:0] v
    );
        widen = v;
    endfunction

    dmx_edge_track u_edge (
        .ref_clk          (ref_clk),
        .srst             (srst),
        .sample_clock_pos (sample_clock_pos),
        .sync_reset_pos   (sync_reset_pos),
        .fall_evt         (fall_evt),
        .rise_evt         (rise_evt),
        .sync_evt         (sync_evt)
    );

    assign dual    = st.ctrl[CTRL_DUAL];
    assign stagger = st.ctrl[CTRL_STAGGER];
    assign div4    = st.ctrl[CTRL_DIV4];
    assign twos    = st.ctrl[CTRL_TWOS];
    assign adv     = fall_evt | rise_evt;

    always_comb
    begin
        next_st = st;
        entry   = '0;

        entry.valid = fall_evt;
        entry.data  = fall_evt ? fmt_word(core_sample, twos) : '0;
        entry.sync  = fall_evt & sync_evt;
        // Sync sample goes to bus B so the marker lands there in dual mode
        entry.sel   = fall_evt & (sync_evt | st.samp_sel);

        if (fall_evt)
        begin
            next_st.samp_sel = sync_evt ? 1'b0 : ~st.samp_sel;
        end

        if (adv)
        begin
            next_st.pipe = {st.pipe[PIPE_DEPTH-2:0], entry};

            if (!dual)
            begin
                if (st.pipe[TAP_SINGLE].valid)
                begin
                    next_st.bus_a  = st.pipe[TAP_SINGLE].data;
                    next_st.mark_a = st.pipe[TAP_SINGLE].sync;
                end
            end
            else
            begin
                if (st.pipe[TAP_EARLY].valid && !st.pipe[TAP_EARLY].sel)
                begin
                    next_st.bus_a  = st.pipe[TAP_EARLY].data;
                    next_st.mark_a = st.pipe[TAP_EARLY].sync;
                end
                if (stagger)
                begin
                    if (st.pipe[TAP_EARLY].valid && st.pipe[TAP_EARLY].sel)
                    begin
                        next_st.bus_b  = st.pipe[TAP_EARLY].data;
                        next_st.mark_b = st.pipe[TAP_EARLY].sync;
                    end
                end
                else
                begin
                    if (st.pipe[TAP_LATE].valid && st.pipe[TAP_LATE].sel)
                    begin
                        next_st.bus_b  = st.pipe[TAP_LATE].data;
                        next_st.mark_b = st.pipe[TAP_LATE].sync;
                    end
                end
            end

            if (sync_evt)
            begin
                next_st.div_cnt = 2'h0;
                next_st.clk_out = 1'b0;
            end
            else if (st.div_cnt >= (div4 ? TOG_DIV4 : TOG_DIV2))
            begin
                next_st.div_cnt = 2'h0;
                next_st.clk_out = ~st.clk_out;
            end
            else
            begin
                next_st.div_cnt = st.div_cnt + 2'h1;
            end
        end

        if (!dual)
        begin
            next_st.bus_b  = '0;
            next_st.mark_b = 1'b0;
        end

        if (sync_evt)
        begin
            next_st.sync_cnt = st.sync_cnt + 8'h01;
        end

        next_st.temp = die_temp;

        if (reg_wr)
        begin
            if (reg_addr == ADDR_CTRL)
            begin
                next_st.ctrl = reg_wdata[3:0];
            end
            else if (reg_addr == ADDR_OFFS)
            begin
                next_st.offs = reg_wdata[OFFS_W-1:0];
            end
            else if (reg_addr == ADDR_GAIN)
            begin
                next_st.gain = reg_wdata[GAIN_W-1:0];
            end
            else if (reg_addr == ADDR_FINE)
            begin
                next_st.fine = reg_wdata[FINE_W-1:0];
            end
            else if (reg_addr == ADDR_COARSE)
            begin
                next_st.coarse = reg_wdata[COARSE_W-1:0];
            end
        end

        // Read data stands for the one cycle after the strobe only
        next_st.rdata = '0;
        if (reg_rd)
        begin
            if (reg_addr == ADDR_CTRL)
            begin
                next_st.rdata = widen({12'h000, st.ctrl});
            end
            else if (reg_addr == ADDR_OFFS)
            begin
                next_st.rdata = widen({7'h00, st.offs});
            end
            else if (reg_addr == ADDR_GAIN)
            begin
                next_st.rdata = widen({4'h0, st.gain});
            end
            else if (reg_addr == ADDR_FINE)
            begin
                next_st.rdata = widen({10'h000, st.fine});
            end
            else if (reg_addr == ADDR_COARSE)
            begin
                next_st.rdata = widen({11'h000, st.coarse});
            end
            else if (reg_addr == ADDR_TEMP)
            begin
                next_st.rdata = widen({8'h00, st.temp});
            end
            else if (reg_addr == ADDR_STATUS)
            begin
                next_st.rdata = widen({5'h00, st.clk_out, st.div_cnt, st.sync_cnt});
            end
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            st        <= '0;
            st.ctrl   <= CTRL_RST;
            st.offs   <= OFFS_RST;
            st.gain   <= GAIN_RST;
            st.fine   <= FINE_RST;
            st.coarse <= COARSE_RST;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign reg_rdata            = st.rdata;
    assign bus_a_data           = st.bus_a;
    assign bus_b_data           = st.bus_b;
    assign sync_marker_bus_a    = st.mark_a;
    assign sync_marker_bus_b    = st.mark_b;
    assign divided_output_clock = st.clk_out;
    assign offset_trim          = st.offs;
    assign gain_trim            = st.gain;
    assign fine_phase_trim      = st.fine;
    assign coarse_phase_trim    = st.coarse;

    default clocking dmx_cb @(posedge ref_clk);
    endclocking
    default disable iff (srst);

    a_fall_starts_conv: assert property (
        fall_evt |=> st.pipe[0].valid
        && st.pipe[0].data == fmt_word($past(core_sample), $past(twos)))
        else $error("Falling edge did not start a conversion");

    a_rise_shifts_pipe: assert property (
        rise_evt |=> !st.pipe[0].valid && st.pipe[1] == $past(st.pipe[0]))
        else $error("Rising edge did not advance the pipeline");

    a_offset_binary_msb: assert property (
        (fall_evt && !twos && !(reg_wr && reg_addr == ADDR_CTRL))
        |=> st.pipe[0].data[DATA_W-1] != $past(core_sample[DATA_W-1]))
        else $error("Offset binary top bit not inverted");

    a_single_latency: assert property (
        (adv && !dual && st.pipe[TAP_SINGLE].valid)
        |=> bus_a_data == $past(st.pipe[TAP_SINGLE].data))
        else $error("Bus A missed the single bus tap");

    a_dual_b_late: assert property (
        (adv && dual && !stagger && st.pipe[TAP_LATE].valid && st.pipe[TAP_LATE].sel
         && !(reg_wr && reg_addr == ADDR_CTRL))
        |=> bus_b_data == $past(st.pipe[TAP_LATE].data))
        else $error("Bus B missed the aligned late tap");

    a_single_b_idle: assert property (
        (!dual && !$past(dual)) |-> bus_b_data == '0 && !sync_marker_bus_b)
        else $error("Bus B active in single bus mode");

    // one marker per event
    // Edges alternate, so the previous sample sits two stages down and must be clean
    a_sync_tagged: assert property (
        sync_evt |=> st.pipe[0].sync && st.pipe[0].sel && !st.pipe[2].sync)
        else $error("Sync event not tagged on exactly one sample");

    a_clk_phase_reset: assert property (
        sync_evt |=> !divided_output_clock && st.div_cnt == 2'h0)
        else $error("Sync event did not reset the output clock phase");

    a_div2_toggle: assert property (
        (adv && !sync_evt && !div4 && st.div_cnt == TOG_DIV2)
        |=> divided_output_clock != $past(divided_output_clock))
        else $error("Output clock did not toggle in divide by 2");

    a_offset_write: assert property (
        (reg_wr && reg_addr == ADDR_OFFS) |=> offset_trim == $past(reg_wdata[OFFS_W-1:0]))
        else $error("Offset trim write lost");

    a_temp_read: assert property (
        (reg_rd && reg_addr == ADDR_TEMP) |=> reg_rdata[TEMP_W-1:0] == $past(st.temp)
        ##1 (reg_rdata == '0 || $past(reg_rd)))
        else $error("Temperature readback wrong");
endmodule // dmx_output_demux
`default_nettype wire

//--- rtl/dmx_pkg.sv
// Package: constants and rule summary for the sample output demux block
// Contract
// - A conversion starts on every falling edge of the sample clock.
// - Samples move one pipeline stage on every sample clock edge.
// - Results are 12-bit words, offset binary or two's complement by setting.
// - Single bus mode puts every sample on bus A, latency 7 cycles.
// - Dual bus mode alternates samples on A and B, latency 7.5 or 8.5.
// - In single bus mode bus B stays idle.
// - Dual bus may be aligned or staggered, output clock divided by 2 or 4.
// - Each captured reset gives exactly one sync marker pulse with the data.
// - The marker has the latency of the sample taken at reset capture.
// - A pulse, a rising step or a pulse train on reset each sync.
// - Every captured reset puts the output clock at one known phase.
// - Offset trim is 9 bits and gain trim 12 bits, programmable.
// - Fine clock phase trim is a 6-bit setting.
// - Coarse clock phase trim is a separate 5-bit setting.
// - Die temperature can be read back by software.
// - Reset input is sampled on the falling edge of the sample clock.
package dmx_pkg;
    localparam int unsigned DATA_W     = 12;
    localparam int unsigned OFFS_W     = 9;
    localparam int unsigned GAIN_W     = 12;
    localparam int unsigned FINE_W     = 6;
    localparam int unsigned COARSE_W   = 5;
    localparam int unsigned TEMP_W     = 8;
    localparam int unsigned ADDR_W     = 4;
    localparam int unsigned REG_W      = 16;
    localparam int unsigned PIPE_DEPTH = 17;

    // Latencies in half sample-clock cycles
    localparam int unsigned LAT_SINGLE_HALF = 14;
    localparam int unsigned LAT_EARLY_HALF  = 15;
    localparam int unsigned LAT_LATE_HALF   = 17;
    localparam int unsigned TAP_SINGLE      = LAT_SINGLE_HALF - 1;
    localparam int unsigned TAP_EARLY       = LAT_EARLY_HALF - 1;
    localparam int unsigned TAP_LATE        = LAT_LATE_HALF - 1;

    // Register indices
    localparam logic [3:0] ADDR_CTRL   = 4'h0;
    localparam logic [3:0] ADDR_OFFS   = 4'h1;
    localparam logic [3:0] ADDR_GAIN   = 4'h2;
    localparam logic [3:0] ADDR_FINE   = 4'h3;
    localparam logic [3:0] ADDR_COARSE = 4'h4;
    localparam logic [3:0] ADDR_TEMP   = 4'h5;
    localparam logic [3:0] ADDR_STATUS = 4'h6;

    // Control field positions
    localparam int unsigned CTRL_DUAL    = 0;
    localparam int unsigned CTRL_STAGGER = 1;
    localparam int unsigned CTRL_DIV4    = 2;
    localparam int unsigned CTRL_TWOS    = 3;

    // Values after reset
    localparam logic [3:0]  CTRL_RST   = 4'h0;
    localparam logic [8:0]  OFFS_RST   = 9'h100;
    localparam logic [11:0] GAIN_RST   = 12'h800;
    localparam logic [5:0]  FINE_RST   = 6'h00;
    localparam logic [4:0]  COARSE_RST = 5'h00;

    // Half-cycle counts between output clock toggles, minus one
    localparam logic [1:0] TOG_DIV2 = 2'h1;
    localparam logic [1:0] TOG_DIV4 = 2'h3;
endpackage
